// ---- design/ces_pkg.sv ----
package ces_pkg;

    // Display limits, raw counts with decimal point dropped
    localparam logic signed [31:0] DISP_LOW = -32'sd19999;
    localparam logic signed [31:0] DISP_HIGH = 32'sd32400;
    // Heater current limit in 0.1 A units (55.0 A)
    localparam logic [15:0] HEATER_CUR_MAX = 16'h0226;
    // Valve opening limits in 0.1 % units (-10.0 % .. 110.0 %)
    localparam logic signed [15:0] VALVE_LOW = -16'sh0064;
    localparam logic signed [15:0] VALVE_HIGH = 16'sh044C;
    // Manipulated value that gives about 0 mA on a current output
    localparam logic [15:0] OUT_ZERO_VALUE = 16'h0000;

    // Screen selector codes
    localparam logic [2:0] SCR_PROC = 3'h0;
    localparam logic [2:0] SCR_PROC_SETPOINT = 3'h1;
    localparam logic [2:0] SCR_PROC_MANIP = 3'h2;

    // Display message codes
    typedef enum logic [6:0] {
        MSG_NORMAL = 7'b000_0001,
        MSG_INPUT_ERR = 7'b000_0010,
        MSG_UNDER = 7'b000_0100,
        MSG_OVER = 7'b000_1000,
        MSG_ADC_ERR = 7'b001_0000,
        MSG_MEM_ERR = 7'b010_0000,
        MSG_BLANK = 7'b100_0000
    } ces_msg_type;

    // Output mode applied to the control output stage
    typedef enum logic [2:0] {
        OUT_NORMAL = 3'b001,
        OUT_FORCED = 3'b010,
        OUT_OFF = 3'b100
    } ces_out_type;

endpackage

// ---- design/ces_fault_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface ces_fault_if;
    logic input_err;
    logic under_range;
    logic over_range;
    logic heater_over;
    logic valve_dash;

    modport src (output input_err, output under_range, output over_range, output heater_over, output valve_dash);
    modport dst (input input_err, input under_range, input over_range, input heater_over, input valve_dash);
endinterface

`default_nettype wire

// ---- design/ces_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

module ces_detect (
    // Measurement
    input wire logic sensor_err,
    input wire logic rtd_sel,
    input wire logic [2:0] rtd_line_open,
    input wire logic signed [31:0] process_value,
    // Heater current, 0.1 A units
    input wire logic [15:0] heater_cur1,
    input wire logic [15:0] heater_cur2,
    input wire logic [15:0] leak_cur1,
    input wire logic [15:0] leak_cur2,
    // Valve position
    input wire logic valve_count_err,
    input wire logic signed [15:0] valve_open,
    // Results
    ces_fault_if.src flt
);

    function automatic logic over_cur(input logic [15:0] cur);
        over_cur = cur > ces_pkg::HEATER_CUR_MAX;
    endfunction

    assign flt.input_err = sensor_err | (rtd_sel & (|rtd_line_open)); // [RULE5]
    assign flt.under_range = process_value < ces_pkg::DISP_LOW; // [RULE6]
    assign flt.over_range = process_value > ces_pkg::DISP_HIGH; // [RULE6]
    assign flt.heater_over = over_cur(heater_cur1) | over_cur(heater_cur2)
        | over_cur(leak_cur1) | over_cur(leak_cur2); // [RULE9]
    assign flt.valve_dash = valve_count_err
        | (valve_open < ces_pkg::VALVE_LOW) | (valve_open > ces_pkg::VALVE_HIGH); // [RULE11]

endmodule

`default_nettype wire

// ---- design/ces_supervisor.sv ----
// Notes on behaviour
// [RULE1] A sensor input error shows the error message and drives the alarms as for a value above the upper limit.
// [RULE2] With input-error-output enabled, the alarm 1 output turns on on any input error.
// [RULE3] The input error message appears only on the three process value screens.
// [RULE4] Input error turns the control output off, or drives the configured manual, stop or error value.
// [RULE5] With a resistance thermometer, an open on any of its three lines is an input error.
// [RULE6] Values below -19999 or above 32400 show under or over patterns, with control continuing.
// [RULE7] A converter fault shows its message and turns control and alarm outputs off.
// [RULE8] A memory fault shows its message and turns all outputs off, current output near 0 mA. Here only control and alarm outputs go off.
// [RULE9] Heater current above 55.0 A shows over-value on all current monitors while control continues.
// [RULE10] Burnout, short or overcurrent lights the heater lamp and flashes the monitor display.
// [RULE11] The valve monitor shows dashes on a count error or opening outside -10 % to 110 %.
// [RULE12] A valve error turns control outputs off or outputs the error value, except under floating control.
// [RULE13] Converter and memory faults override input error and valve error output handling.
`timescale 1ns/1ps
`default_nettype none

module ces_supervisor #(
    parameter int ALARM_N = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Fault sources
    input wire logic sensor_err,
    input wire logic rtd_sel,
    input wire logic [2:0] rtd_line_open,
    input wire logic signed [31:0] process_value,
    input wire logic adc_fault,
    input wire logic mem_fault,
    input wire logic [15:0] heater_cur1,
    input wire logic [15:0] heater_cur2,
    input wire logic [15:0] leak_cur1,
    input wire logic [15:0] leak_cur2,
    input wire logic heater_burnout,
    input wire logic heater_short_alarm,
    input wire logic heater_overcur,
    input wire logic valve_count_err,
    input wire logic signed [15:0] valve_open,
    // Configuration
    input wire logic input_err_out_en,
    input wire logic [2:0] screen_sel,
    input wire logic override_en,
    input wire logic [15:0] override_value,
    input wire logic floating_ctrl,
    input wire logic flash_tick,
    // Normal control path
    input wire logic [15:0] ctrl_manipulated_value,
    input wire logic [ALARM_N-1:0] alarm_normal,
    input wire logic [ALARM_N-1:0] alarm_upper,
    // Outputs
    output logic [15:0] ctrl_out_r,
    output logic [2:0] ctrl_mode_r,
    output logic [ALARM_N-1:0] alarm_out_r,
    output logic heater_alarm_lamp_r,
    output logic heater_disp_flash_r,
    output logic heater_disp_over_r,
    output logic [6:0] main_msg_r,
    output logic valve_dash_r,
    output logic input_err_r
);

    ces_fault_if flt ();

    ces_detect u_detect (
        .sensor_err(sensor_err),
        .rtd_sel(rtd_sel),
        .rtd_line_open(rtd_line_open),
        .process_value(process_value),
        .heater_cur1(heater_cur1),
        .heater_cur2(heater_cur2),
        .leak_cur1(leak_cur1),
        .leak_cur2(leak_cur2),
        .valve_count_err(valve_count_err),
        .valve_open(valve_open),
        .flt(flt)
    );

    logic hard_fault;
    logic valve_stop;
    logic value_screen;
    logic heater_event;
    logic flash_phase_r;
    logic [2:0] ctrl_mode_nxt;
    logic [15:0] ctrl_out_nxt;
    logic [ALARM_N-1:0] alarm_nxt;
    logic [6:0] main_msg_nxt;

    assign hard_fault = adc_fault | mem_fault;
    assign valve_stop = flt.valve_dash & ~floating_ctrl; // [RULE12]
    assign value_screen = (screen_sel == ces_pkg::SCR_PROC) | (screen_sel == ces_pkg::SCR_PROC_SETPOINT)
        | (screen_sel == ces_pkg::SCR_PROC_MANIP);
    assign heater_event = heater_burnout | heater_short_alarm | heater_overcur;

    // Control output selection
    always_comb begin
        ctrl_mode_nxt = ces_pkg::OUT_NORMAL;
        ctrl_out_nxt = ctrl_manipulated_value;
        if (hard_fault) begin
            ctrl_mode_nxt = ces_pkg::OUT_OFF; // [RULE7] [RULE8] [RULE13]
            ctrl_out_nxt = ces_pkg::OUT_ZERO_VALUE;
        end else if (flt.input_err || valve_stop) begin
            if (override_en) begin
                ctrl_mode_nxt = ces_pkg::OUT_FORCED; // [RULE4] [RULE12]
                ctrl_out_nxt = override_value;
            end else begin
                ctrl_mode_nxt = ces_pkg::OUT_OFF; // [RULE4] [RULE12]
                ctrl_out_nxt = ces_pkg::OUT_ZERO_VALUE;
            end
        end
    end

    // Alarm output selection
    always_comb begin
        alarm_nxt = alarm_normal;
        if (hard_fault) begin
            alarm_nxt = '0; // [RULE7] [RULE8] [RULE13]
        end else if (flt.input_err) begin
            alarm_nxt = alarm_upper; // [RULE1]
            if (input_err_out_en) begin
                alarm_nxt[0] = 1'b1; // [RULE2]
            end
        end
    end

    // Main display message
    always_comb begin
        main_msg_nxt = ces_pkg::MSG_NORMAL;
        if (mem_fault) begin
            main_msg_nxt = ces_pkg::MSG_MEM_ERR; // [RULE8]
        end else if (adc_fault) begin
            main_msg_nxt = ces_pkg::MSG_ADC_ERR; // [RULE7]
        end else if (!value_screen) begin
            main_msg_nxt = ces_pkg::MSG_NORMAL; // [RULE3]
        end else if (flt.input_err) begin
            main_msg_nxt = ces_pkg::MSG_INPUT_ERR; // [RULE1] [RULE3]
        end else if (flt.under_range) begin
            main_msg_nxt = ces_pkg::MSG_UNDER; // [RULE6]
        end else if (flt.over_range) begin
            main_msg_nxt = ces_pkg::MSG_OVER; // [RULE6]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_mode_r <= ces_pkg::OUT_OFF;
            ctrl_out_r <= ces_pkg::OUT_ZERO_VALUE;
        end else begin
            ctrl_mode_r <= ctrl_mode_nxt;
            ctrl_out_r <= ctrl_out_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            alarm_out_r <= '0;
            input_err_r <= 1'b0;
        end else begin
            alarm_out_r <= alarm_nxt;
            input_err_r <= flt.input_err;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            main_msg_r <= ces_pkg::MSG_NORMAL;
            valve_dash_r <= 1'b0;
            heater_disp_over_r <= 1'b0;
        end else begin
            main_msg_r <= main_msg_nxt;
            valve_dash_r <= flt.valve_dash; // [RULE11]
            heater_disp_over_r <= flt.heater_over; // [RULE9]
        end
    end

    // Heater lamp and monitor flashing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flash_phase_r <= 1'b0;
            heater_alarm_lamp_r <= 1'b0;
            heater_disp_flash_r <= 1'b0;
        end else begin
            if (flash_tick) begin
                flash_phase_r <= ~flash_phase_r;
            end
            heater_alarm_lamp_r <= heater_event; // [RULE10]
            heater_disp_flash_r <= heater_event & flash_phase_r; // [RULE10]
        end
    end

endmodule

`default_nettype wire

// ---- dv/ces_supervisor_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module ces_supervisor_chk #(
    parameter int ALARM_N = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic sensor_err,
    input wire logic rtd_sel,
    input wire logic [2:0] rtd_line_open,
    input wire logic adc_fault,
    input wire logic mem_fault,
    input wire logic heater_burnout,
    input wire logic valve_count_err,
    input wire logic input_err_out_en,
    input wire logic [2:0] screen_sel,
    input wire logic override_en,
    input wire logic [ALARM_N-1:0] alarm_upper,
    // Watched outputs
    input wire logic [15:0] ctrl_out_r,
    input wire logic [2:0] ctrl_mode_r,
    input wire logic [ALARM_N-1:0] alarm_out_r,
    input wire logic heater_alarm_lamp_r,
    input wire logic [6:0] main_msg_r,
    input wire logic valve_dash_r,
    input wire logic input_err_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Input error without an overriding internal fault
    sequence in_err_s;
        sensor_err && !adc_fault && !mem_fault;
    endsequence
    alarm_upper_a: assert property (in_err_s and !input_err_out_en
        |=> input_err_r && alarm_out_r == $past(alarm_upper))
        else $error("alarms not as for upper limit");
    alarm_one_a: assert property (in_err_s and input_err_out_en |=> alarm_out_r[0])
        else $error("alarm 1 not on at input error");
    err_msg_a: assert property (in_err_s and screen_sel == ces_pkg::SCR_PROC_SETPOINT
        |=> main_msg_r == ces_pkg::MSG_INPUT_ERR)
        else $error("input error message missing");
    ctrl_off_a: assert property (in_err_s and !override_en
        |=> ctrl_mode_r == ces_pkg::OUT_OFF && ctrl_out_r == 16'h0000)
        else $error("control output not off");
    rtd_open_a: assert property (rtd_sel && rtd_line_open != 3'h0 && !adc_fault && !mem_fault
        |=> input_err_r)
        else $error("open line not an input error");
    adc_off_a: assert property (adc_fault && !mem_fault
        |=> main_msg_r == ces_pkg::MSG_ADC_ERR && ctrl_mode_r == ces_pkg::OUT_OFF && alarm_out_r == '0)
        else $error("converter fault outputs wrong");
    mem_off_a: assert property (mem_fault
        |=> main_msg_r == ces_pkg::MSG_MEM_ERR && ctrl_out_r == ces_pkg::OUT_ZERO_VALUE && alarm_out_r == '0)
        else $error("memory fault outputs wrong");
    lamp_on_a: assert property (heater_burnout |=> heater_alarm_lamp_r)
        else $error("heater lamp not lit");
    valve_dash_a: assert property (valve_count_err |=> valve_dash_r)
        else $error("valve dashes missing");
endmodule

bind ces_supervisor ces_supervisor_chk #(.ALARM_N(ALARM_N)) i_ces_supervisor_chk (.*);

`default_nettype wire

// ---- dv/tb_ces_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_ces_supervisor;
    localparam int ALARM_N = 2;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sensor_err, rtd_sel, adc_fault, mem_fault, heater_burnout, heater_short_alarm, heater_overcur;
    logic valve_count_err, input_err_out_en, override_en, floating_ctrl, flash_tick, f0;
    logic [2:0] rtd_line_open, screen_sel, ctrl_mode_r;
    logic signed [31:0] process_value;
    logic signed [15:0] valve_open;
    logic [15:0] heater_cur1, heater_cur2, leak_cur1, leak_cur2, override_value, ctrl_manipulated_value, ctrl_out_r;
    logic [ALARM_N-1:0] alarm_normal, alarm_upper, alarm_out_r;
    logic heater_alarm_lamp_r, heater_disp_flash_r, heater_disp_over_r, valve_dash_r, input_err_r;
    logic [6:0] main_msg_r;
    logic signed [31:0] proc_t [4] = '{-32'sd19999, -32'sd20000, 32'sd32400, 32'sd32401};
    logic [6:0] proc_m [4] = '{ces_pkg::MSG_NORMAL, ces_pkg::MSG_UNDER, ces_pkg::MSG_NORMAL, ces_pkg::MSG_OVER};
    logic signed [15:0] vo_t [5] = '{16'sh0000, -16'sh0065, 16'sh044D, 16'sh044C, -16'sh0064};
    int n_mismatch = 0;
    int checks_done = 0;

    ces_supervisor #(.ALARM_N(ALARM_N)) i_ces_supervisor (.*);

    always #4 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic ctl(input logic [2:0] m, input logic [15:0] v);
        chk("ctrl_mode", ctrl_mode_r, m);
        chk("ctrl_out", ctrl_out_r, v);
    endtask
    task automatic clr();
        {sensor_err, rtd_sel, adc_fault, mem_fault, heater_burnout, heater_short_alarm, heater_overcur} <= '0;
        {valve_count_err, input_err_out_en, override_en, floating_ctrl, flash_tick, rtd_line_open} <= '0;
        {screen_sel, process_value, valve_open, heater_cur1, heater_cur2, leak_cur1, leak_cur2} <= '0;
        {override_value, ctrl_manipulated_value} <= {16'h0123, 16'h0042};
        {alarm_normal, alarm_upper} <= {2'b01, 2'b10};
    endtask
    task automatic tick();
        @(posedge sys_clk);
    endtask
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #20us;
        n_mismatch++;
        final_report();
    end

    initial begin
        clr();
        repeat (6) step();
        ctl(ces_pkg::OUT_OFF, 16'h0000);
        chk("rst msg", main_msg_r, ces_pkg::MSG_NORMAL);
        tick();
        rst_n <= 1'b1;
        tick();
        sensor_err <= 1'b1;
        step();
        chk("in err", input_err_r, 1'b1);
        chk("alarms", alarm_out_r, 2'b10);
        ctl(ces_pkg::OUT_OFF, 16'h0000);
        tick();
        {input_err_out_en, override_en} <= 2'b11;
        step();
        chk("alarm1", alarm_out_r, 2'b11);
        ctl(ces_pkg::OUT_FORCED, 16'h0123);
        for (int s = 0; s < 8; s++) begin
            tick();
            screen_sel <= 3'(s);
            step();
            chk("msg scr", main_msg_r, s < 3 ? ces_pkg::MSG_INPUT_ERR : ces_pkg::MSG_NORMAL);
        end
        tick();
        clr();
        tick();
        rtd_sel <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            tick();
            rtd_line_open <= 3'b001 << i;
            step();
            chk("rtd open", input_err_r, 1'b1);
        end
        tick();
        clr();
        for (int i = 0; i < 4; i++) begin
            tick();
            process_value <= proc_t[i];
            step();
            chk("range msg", main_msg_r, proc_m[i]);
            ctl(ces_pkg::OUT_NORMAL, 16'h0042);
        end
        for (int i = 0; i < 8; i++) begin
            tick();
            {heater_cur1, heater_cur2, leak_cur1, leak_cur2} <= 64'(16'h0226 + 16'(i % 2)) << (16 * (3 - i / 2));
            step();
            chk("cur over", heater_disp_over_r, 32'(i % 2));
            ctl(ces_pkg::OUT_NORMAL, 16'h0042);
        end
        for (int i = 0; i < 3; i++) begin
            tick();
            {heater_burnout, heater_short_alarm, heater_overcur} <= 3'b100 >> i;
            step();
            chk("lamp", heater_alarm_lamp_r, 1'b1);
            ctl(ces_pkg::OUT_NORMAL, 16'h0042);
        end
        f0 = heater_disp_flash_r;
        tick();
        flash_tick <= 1'b1;
        tick();
        flash_tick <= 1'b0;
        repeat (2) step();
        chk("flash", heater_disp_flash_r, !f0);
        tick();
        clr();
        for (int i = 0; i < 5; i++) begin
            tick();
            {valve_count_err, floating_ctrl} <= {i == 0, i == 2};
            valve_open <= vo_t[i];
            step();
            chk("dash", valve_dash_r, i < 3);
            chk("valve mode", ctrl_mode_r, i < 2 ? ces_pkg::OUT_OFF : ces_pkg::OUT_NORMAL);
        end
        tick();
        {sensor_err, valve_count_err, adc_fault, input_err_out_en} <= 4'hF;
        step();
        chk("adc msg", main_msg_r, ces_pkg::MSG_ADC_ERR);
        chk("adc alarms", alarm_out_r, 2'b00);
        ctl(ces_pkg::OUT_OFF, 16'h0000);
        tick();
        mem_fault <= 1'b1;
        step();
        chk("mem msg", main_msg_r, ces_pkg::MSG_MEM_ERR);
        chk("mem alarms", alarm_out_r, 2'b00);
        ctl(ces_pkg::OUT_OFF, ces_pkg::OUT_ZERO_VALUE);
        step();
        final_report();
    end
endmodule

`default_nettype wire
